/* core/p0rx_pkg.sv */
// shared constants and types for the port 0 receive input stage
package p0rx_pkg;

    // ------------------------------------------------------------------
    // port 0 operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        P0RX_MODE_MII_MAC,
        P0RX_MODE_MII_PHY,
        P0RX_MODE_RMII_PHY,
        P0RX_MODE_RSVD
    } p0rx_mode_type;

    // ------------------------------------------------------------------
    // pin and word layout
    // ------------------------------------------------------------------
    localparam int unsigned NIBBLE_W   = 4;
    localparam int unsigned DIBIT_W    = 2;
    localparam int unsigned WORD_W     = 9;
    localparam int unsigned W_DATA_LSB = 0;
    localparam int unsigned W_DIBIT    = 4;
    localparam int unsigned W_FIRST    = 5;
    localparam int unsigned W_LAST     = 6;
    localparam int unsigned W_ERR      = 7;
    localparam int unsigned W_ABORT    = 8;

    localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO = 4'h0;
    localparam logic [NIBBLE_W-1:0] DIBIT_MASK  = 4'h3;
    localparam logic [WORD_W-1:0]   WORD_ZERO   = 9'h000;

endpackage

/* core/p0rx_input_stage.sv */
// port 0 receive input stage: pin capture on the link clock, crossing, two-entry buffer
//
// Functional notes
// RULE1 - MII MAC mode: input bits 1 and 0 are receive nibble bits 1 and 0.
// RULE2 - PHY modes: external MAC drives bits 1 and 0 with its transmit data.
// RULE3 - PHY modes with isolate set: input buffers and pull-downs are disabled.
// RULE4 - MII MAC mode: data and error only meaningful while data-valid is asserted.
// RULE5 - MII PHY mode: external MAC asserts TX_EN whenever nibble and error are valid.
// RULE6 - RMII PHY mode: data-valid qualifies only the dibit; upper bits ignored.
// RULE7 - MII MAC mode: error input marks the current packet as a receive error.
// RULE8 - MII PHY mode: error input aborts the current packet.
// RULE9 - RMII PHY mode: error input unused; no error or abort taken from it.
// RULE10 - input reference clock times data, data-valid and error pins.
// RULE11 - pins sampled on the rising edge of the input reference clock.
module p0rx_input_stage
    import p0rx_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                port0_in_refclk_i,
    input  wire logic [NIBBLE_W-1:0] port0_in_nibble_i,
    input  wire logic                port0_in_valid_i,
    input  wire logic                port0_in_error_i,
    input  wire logic [1:0]          port0_mode_i,
    input  wire logic                virtual_phy_isolate_i,
    output logic                     pad_buffer_enable_o,
    output logic                     pad_pulldown_enable_o,
    output logic                     rx_valid_o,
    input  wire logic                rx_ready_i,
    output logic [NIBBLE_W-1:0]      rx_data_o,
    output logic                     rx_dibit_o,
    output logic                     rx_first_o,
    output logic                     rx_last_o,
    output logic                     rx_error_o,
    output logic                     rx_abort_o,
    output logic                     rx_overflow_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // isolate only bites in the two phy modes
    function automatic logic iso_active(input logic [1:0] mode, input logic iso);
        iso_active = iso && (mode == P0RX_MODE_MII_PHY || mode == P0RX_MODE_RMII_PHY);
    endfunction

    // ------------------------------------------------------------------
    // system domain: pad control
    // ------------------------------------------------------------------
    logic [1:0] cfg_mode_q,  cfg_mode_d;
    logic       cfg_iso_q,   cfg_iso_d;
    logic       pad_en_q,    pad_en_d;

    // mode and isolate are quasi-static controls from the same clock
    always_comb begin
        cfg_mode_d = port0_mode_i;
        cfg_iso_d  = virtual_phy_isolate_i;
        pad_en_d   = !iso_active(cfg_mode_q, cfg_iso_q);   // RULE3
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_mode_q <= P0RX_MODE_MII_MAC;
            cfg_iso_q  <= 1'b0;
            pad_en_q   <= 1'b1;
        end else begin
            cfg_mode_q <= cfg_mode_d;
            cfg_iso_q  <= cfg_iso_d;
            pad_en_q   <= pad_en_d;
        end
    end

    assign pad_buffer_enable_o   = pad_en_q;
    assign pad_pulldown_enable_o = pad_en_q;

    // ------------------------------------------------------------------
    // link domain: control synchronisers and pin capture
    // ------------------------------------------------------------------
    // rst_i crosses through two link flops; without it the toggle would start
    // unknown and never settle, so the link clock must run during reset
    logic                lk_rst_s1,  lk_rst_s2;
    logic [1:0]          lk_mode_s1, lk_mode_s2;
    logic                lk_iso_s1,  lk_iso_s2;
    logic [NIBBLE_W-1:0] lk_nib_q;
    logic                lk_dv_q, lk_er_q;

    // rising edge capture of the pins and two-stage sync of the controls
    always_ff @(posedge port0_in_refclk_i) begin   // RULE10 RULE11
        lk_rst_s1  <= rst_i;
        lk_rst_s2  <= lk_rst_s1;
        lk_mode_s1 <= cfg_mode_q;
        lk_mode_s2 <= lk_mode_s1;
        lk_iso_s1  <= cfg_iso_q;
        lk_iso_s2  <= lk_iso_s1;
        lk_nib_q   <= port0_in_nibble_i;
        lk_dv_q    <= port0_in_valid_i;
        lk_er_q    <= port0_in_error_i;
    end

    // ------------------------------------------------------------------
    // link domain: symbol qualification and word build
    // ------------------------------------------------------------------
    logic              lk_frame_q, lk_frame_d;
    logic              lk_ferr_q,  lk_ferr_d;
    logic              lk_fabt_q,  lk_fabt_d;
    logic [WORD_W-1:0] lk_word_q,  lk_word_d;
    logic              lk_tog_q,   lk_tog_d;

    always_comb begin
        logic dv;
        logic rmii;
        logic sym_err;
        logic sym_abt;
        dv      = lk_dv_q && !iso_active(lk_mode_s2, lk_iso_s2);   // RULE3
        rmii    = (lk_mode_s2 == P0RX_MODE_RMII_PHY);
        sym_err = dv && lk_er_q && (lk_mode_s2 == P0RX_MODE_MII_MAC);   // RULE4 RULE7
        sym_abt = dv && lk_er_q && (lk_mode_s2 == P0RX_MODE_MII_PHY);   // RULE8 RULE9
        lk_frame_d = lk_frame_q;
        lk_ferr_d  = lk_ferr_q;
        lk_fabt_d  = lk_fabt_q;
        lk_word_d  = lk_word_q;
        lk_tog_d   = lk_tog_q;
        if (dv) begin
            // only symbols inside the valid window are forwarded as data words; the closing word follows after it
            lk_word_d = WORD_ZERO;
            lk_word_d[W_DATA_LSB +: NIBBLE_W] =
                rmii ? (lk_nib_q & DIBIT_MASK) : lk_nib_q;   // RULE1 RULE2 RULE6
            lk_word_d[W_DIBIT] = rmii;                       // RULE6
            lk_word_d[W_FIRST] = !lk_frame_q;
            lk_word_d[W_ERR]   = sym_err;
            lk_word_d[W_ABORT] = sym_abt;
            lk_frame_d = 1'b1;
            lk_ferr_d  = (lk_frame_q && lk_ferr_q) || sym_err;   // RULE7
            lk_fabt_d  = (lk_frame_q && lk_fabt_q) || sym_abt;   // RULE8
            lk_tog_d   = !lk_tog_q;
        end else if (lk_frame_q) begin
            // closing word carries the whole-packet error and abort marks
            lk_word_d = WORD_ZERO;
            lk_word_d[W_DIBIT] = rmii;
            lk_word_d[W_LAST]  = 1'b1;
            lk_word_d[W_ERR]   = lk_ferr_q;   // RULE7
            lk_word_d[W_ABORT] = lk_fabt_q;   // RULE8
            lk_frame_d = 1'b0;
            lk_tog_d   = !lk_tog_q;
        end
    end

    // toggle resets to the same level as the system side synchronisers
    always_ff @(posedge port0_in_refclk_i) begin
        if (lk_rst_s2) begin
            lk_frame_q <= 1'b0;
            lk_ferr_q  <= 1'b0;
            lk_fabt_q  <= 1'b0;
            lk_word_q  <= WORD_ZERO;
            lk_tog_q   <= 1'b0;
        end else begin
            lk_frame_q <= lk_frame_d;
            lk_ferr_q  <= lk_ferr_d;
            lk_fabt_q  <= lk_fabt_d;
            lk_word_q  <= lk_word_d;
            lk_tog_q   <= lk_tog_d;
        end
    end

    // ------------------------------------------------------------------
    // system domain: toggle crossing
    // ------------------------------------------------------------------
    // the word is held for a whole link period, far longer than the sync delay
    logic              sy_tog_s1, sy_tog_s2, sy_tog_s3;
    logic              sy_pend_q, sy_pend_d;
    logic [WORD_W-1:0] sy_word_q, sy_word_d;
    logic              sy_ovf_q,  sy_ovf_d;
    logic              sy_new;
    logic              buf_ready;

    assign sy_new = sy_tog_s2 ^ sy_tog_s3;

    // pending word stalls until the buffer has room
    always_comb begin
        sy_pend_d = sy_pend_q;
        sy_word_d = sy_word_q;
        sy_ovf_d  = sy_ovf_q;
        if (sy_pend_q && buf_ready) begin
            sy_pend_d = 1'b0;
        end
        if (sy_new) begin
            if (sy_pend_q && !buf_ready) begin
                sy_ovf_d = 1'b1;   // receiver stalled across a whole symbol
            end else begin
                sy_pend_d = 1'b1;
                sy_word_d = lk_word_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy_tog_s1 <= 1'b0;
            sy_tog_s2 <= 1'b0;
            sy_tog_s3 <= 1'b0;
            sy_pend_q <= 1'b0;
            sy_word_q <= WORD_ZERO;
            sy_ovf_q  <= 1'b0;
        end else begin
            sy_tog_s1 <= lk_tog_q;
            sy_tog_s2 <= sy_tog_s1;
            sy_tog_s3 <= sy_tog_s2;
            sy_pend_q <= sy_pend_d;
            sy_word_q <= sy_word_d;
            sy_ovf_q  <= sy_ovf_d;
        end
    end

    // ------------------------------------------------------------------
    // system domain: two-entry buffer (output stage plus skid)
    // ------------------------------------------------------------------
    logic              out_vld_q,  out_vld_d;
    logic [WORD_W-1:0] out_word_q, out_word_d;
    logic              skd_vld_q,  skd_vld_d;
    logic [WORD_W-1:0] skd_word_q, skd_word_d;
    logic              push;

    assign buf_ready = !skd_vld_q;
    assign push      = sy_pend_q && buf_ready;

    // outputs stay flop-driven; the skid entry absorbs one stall cycle
    always_comb begin
        out_vld_d  = out_vld_q;
        out_word_d = out_word_q;
        skd_vld_d  = skd_vld_q;
        skd_word_d = skd_word_q;
        if (!out_vld_q || rx_ready_i) begin
            if (skd_vld_q) begin
                out_vld_d  = 1'b1;
                out_word_d = skd_word_q;
                skd_vld_d  = 1'b0;
                if (push) begin
                    skd_vld_d  = 1'b1;
                    skd_word_d = sy_word_q;
                end
            end else begin
                out_vld_d  = push;
                out_word_d = push ? sy_word_q : out_word_q;
            end
        end else if (push) begin
            skd_vld_d  = 1'b1;
            skd_word_d = sy_word_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_vld_q  <= 1'b0;
            out_word_q <= WORD_ZERO;
            skd_vld_q  <= 1'b0;
            skd_word_q <= WORD_ZERO;
        end else begin
            out_vld_q  <= out_vld_d;
            out_word_q <= out_word_d;
            skd_vld_q  <= skd_vld_d;
            skd_word_q <= skd_word_d;
        end
    end

    assign rx_valid_o    = out_vld_q;
    assign rx_data_o     = out_word_q[W_DATA_LSB +: NIBBLE_W];
    assign rx_dibit_o    = out_word_q[W_DIBIT];
    assign rx_first_o    = out_word_q[W_FIRST];
    assign rx_last_o     = out_word_q[W_LAST];
    assign rx_error_o    = out_word_q[W_ERR];
    assign rx_abort_o    = out_word_q[W_ABORT];
    assign rx_overflow_o = sy_ovf_q;

endmodule

/* bench/p0rx_monitor.sv */
// checker for the port 0 receive stage output stream and pad controls
module p0rx_monitor
    import p0rx_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic [1:0]          port0_mode_i,
    input wire logic                virtual_phy_isolate_i,
    input wire logic                pad_buffer_enable_o,
    input wire logic                pad_pulldown_enable_o,
    input wire logic                rx_valid_o,
    input wire logic                rx_ready_i,
    input wire logic [NIBBLE_W-1:0] rx_data_o,
    input wire logic                rx_dibit_o,
    input wire logic                rx_first_o,
    input wire logic                rx_last_o,
    input wire logic                rx_error_o,
    input wire logic                rx_abort_o,
    input wire logic                rx_overflow_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // isolate only bites in the two phy modes; mac mode keeps its pads live
    wire iso_w = virtual_phy_isolate_i && (port0_mode_i inside {2'h1, 2'h2});
    sequence s_iso_held; iso_w [*3]; endsequence
    sequence s_open_held; !iso_w [*3]; endsequence
    sequence s_word(logic [1:0] m); rx_valid_o && port0_mode_i == m; endsequence
    property p_pad_off; s_iso_held |-> !pad_buffer_enable_o && !pad_pulldown_enable_o; endproperty
    property p_pad_on; s_open_held |-> pad_buffer_enable_o && pad_pulldown_enable_o; endproperty
    property p_hold;
        rx_valid_o && !rx_ready_i |=> rx_valid_o
            && $stable({rx_data_o, rx_first_o, rx_last_o, rx_error_o, rx_abort_o});
    endproperty
    property p_sticky; rx_overflow_o |=> rx_overflow_o; endproperty
    property p_mac; s_word(2'h0) |-> !rx_abort_o && !rx_dibit_o; endproperty
    property p_phy; s_word(2'h1) |-> !rx_error_o && !rx_dibit_o; endproperty
    property p_rmii;
        s_word(2'h2) |-> !rx_error_o && !rx_abort_o && (rx_last_o || rx_dibit_o)
            && rx_data_o[3:2] == 2'h0;
    endproperty
    property p_last; rx_valid_o && rx_last_o |-> !rx_first_o && rx_data_o == 4'h0; endproperty
    a_pad_off: assert property (p_pad_off) else $error("pads live while isolated");
    a_pad_on: assert property (p_pad_on) else $error("pads off while not isolated");
    a_hold: assert property (p_hold) else $error("word changed before taken");
    a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
    a_mac: assert property (p_mac) else $error("abort or dibit in mac mode");
    a_phy: assert property (p_phy) else $error("error or dibit in mii phy mode");
    a_rmii: assert property (p_rmii) else $error("bad rmii word");
    a_last: assert property (p_last) else $error("end marker carries data");
endmodule

bind p0rx_input_stage p0rx_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .port0_mode_i(port0_mode_i),
    .virtual_phy_isolate_i(virtual_phy_isolate_i), .pad_buffer_enable_o(pad_buffer_enable_o),
    .pad_pulldown_enable_o(pad_pulldown_enable_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .rx_dibit_o(rx_dibit_o),
    .rx_first_o(rx_first_o), .rx_last_o(rx_last_o), .rx_error_o(rx_error_o),
    .rx_abort_o(rx_abort_o), .rx_overflow_o(rx_overflow_o));

/* bench/p0rx_phy_model.sv */
// behavioural external phy or mac driving the port 0 receive pins
module p0rx_phy_model (
    output logic       refclk_o,
    output logic [3:0] nibble_o,
    output logic       valid_o,
    output logic       error_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // receive clock runs free as a phy keeps it; odd offset keeps it off the system edges
    initial begin
        refclk_o = 1'b0;
        nibble_o = 4'h0;
        valid_o = 1'b0;
        error_o = 1'b0;
        #7;
        forever begin
            #32;
            refclk_o = ~refclk_o;
        end
    end
    // pins change on the falling edge so the rising edge sees them settled
    task automatic send(input logic [15:0] nibs, input int n, input int err_at);
        repeat (4) @(negedge refclk_o);
        for (int i = 0; i < n; i++) begin
            @(negedge refclk_o);
            valid_o = 1'b1;
            nibble_o = nibs[4*i +: 4];
            error_o = (i == err_at);
        end
        @(negedge refclk_o);
        valid_o = 1'b0;
        error_o = 1'b0;
        nibble_o = 4'h0; // released lines fall to the pull-downs
        repeat (3) @(negedge refclk_o);
    endtask
endmodule

/* bench/p0rx_input_stage_tb.sv */
// self-checking bench for the port 0 receive input stage
module p0rx_input_stage_tb
    import p0rx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_i = 1'b0, rst_i = 1'b1, rx_ready_i = 1'b1, iso = 1'b0;
    logic [1:0] mode = 2'h0;
    wire        refclk, dv, er, pad_en, pd_en, rx_valid, rx_dibit, rx_first, rx_last;
    wire        rx_err, rx_abort, ovf;
    wire [3:0]  nib, rx_data;
    logic [8:0] got[$];
    int         err_total = 0, tests_run = 0, cyc = 0;

    p0rx_phy_model u_phy (.refclk_o(refclk), .nibble_o(nib), .valid_o(dv), .error_o(er));
    p0rx_input_stage u_dut (.clk_i(clk_i), .rst_i(rst_i), .port0_in_refclk_i(refclk),
        .port0_in_nibble_i(nib), .port0_in_valid_i(dv), .port0_in_error_i(er),
        .port0_mode_i(mode), .virtual_phy_isolate_i(iso), .pad_buffer_enable_o(pad_en),
        .pad_pulldown_enable_o(pd_en), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_i),
        .rx_data_o(rx_data), .rx_dibit_o(rx_dibit), .rx_first_o(rx_first),
        .rx_last_o(rx_last), .rx_error_o(rx_err), .rx_abort_o(rx_abort), .rx_overflow_o(ovf));

    // ------------------------------------------------------------------
    // clock, word collector and hang guard
    // ------------------------------------------------------------------
    initial forever #2 clk_i = ~clk_i;
    // taken words packed as abort, error, last, first, dibit, data
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rx_valid && rx_ready_i) begin
            got.push_back({rx_abort, rx_err, rx_last, rx_first, rx_dibit, rx_data});
        end
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one frame in one mode, error pin raised on symbol ea (none if ea >= n)
    task automatic frame_test(input logic [1:0] m, input logic [15:0] nibs,
                              input int n, input int ea);
        logic [3:0] d;
        logic       rm;
        logic [8:0] e;
        @(posedge clk_i);
        mode <= m;
        repeat (4) @(posedge clk_i);
        got.delete();
        u_phy.send(nibs, n, ea);
        repeat (24) @(posedge clk_i);
        rm = (m == P0RX_MODE_RMII_PHY);
        chk("word count", 9'(n + 1), 9'(got.size()));
        for (int i = 0; i < n; i++) begin
            d = rm ? (nibs[4*i +: 4] & DIBIT_MASK) : nibs[4*i +: 4];
            e = {m == 2'h1 && i == ea, m == 2'h0 && i == ea, 1'b0, i == 0, rm, d};
            chk("data word", e, got[i]);
        end
        // end marker: last set, first clear, no data, dibit flag per mode
        e = {m == 2'h1 && ea < n, m == 2'h0 && ea < n, 2'h2, rm, 4'h0};
        chk("end marker", e, got[n]);
    endtask
    task automatic isolate_test();
        @(posedge clk_i);
        mode <= P0RX_MODE_MII_PHY;
        iso <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("pads isolated", 9'h000, {7'h00, pad_en, pd_en});
        got.delete();
        u_phy.send(16'h00a5, 3, 9);
        repeat (24) @(posedge clk_i);
        chk("words while isolated", 9'h000, 9'(got.size()));
        iso <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("pads restored", 9'h003, {7'h00, pad_en, pd_en});
    endtask
    // receiver stalls through a whole frame; overflow must stick, first word survive
    task automatic stall_test();
        @(posedge clk_i);
        mode <= P0RX_MODE_MII_MAC;
        rx_ready_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        got.delete();
        u_phy.send(16'h4321, 4, 9);
        repeat (24) @(posedge clk_i);
        chk("stalled valid and overflow", 9'h003, {7'h00, rx_valid, ovf});
        rx_ready_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("first word kept", 9'h021, got[0]);
        chk("drained", 9'h001, {7'h00, rx_valid, ovf});
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        frame_test(P0RX_MODE_MII_MAC, 16'ha5c3, 4, 1);
        frame_test(P0RX_MODE_MII_MAC, 16'h00f0, 2, 9);
        frame_test(P0RX_MODE_MII_PHY, 16'h5a3c, 4, 3);
        frame_test(P0RX_MODE_RMII_PHY, 16'hfedb, 4, 0);
        frame_test(P0RX_MODE_RSVD, 16'h0e7c, 3, 1);
        iso <= 1'b1;
        frame_test(P0RX_MODE_MII_MAC, 16'h0069, 2, 9);
        iso <= 1'b0;
        isolate_test();
        stall_test();
        conclude();
    end
endmodule
